//--- hw/pcr_pkg.sv
// pcr_pkg: register indices, field positions, reset values, enums and
// timing constants for the palette control register bank.
// assumes an 8-bit indexed host register port and a 20 MHz clk_i.
// Function
// R1: general-control at index 1d, host read/write any time, bit 7 on data bit 7.
// R2: general bit 7 picks overscan source: 0 external pin, 1 internal.
// R3: general bit 6 set enables overscan borders; reset 0.
// R4: general bit 5 puts sync onto green output; reset 1.
// R5: general bit 4 selects pedestal: 0 gives 0 IRE, 1 gives 7.5 IRE.
// R6: general bit 3 selects pixel byte order: 0 little, 1 big endian.
// R7: general bit 2 enables split transfer extra shift pulse; reset 0.
// R8: general bit 1 sets vertical sync output polarity; 0 active low.
// R9: general bit 0 sets horizontal sync output polarity; 0 active low.
// R10: cursor-control at index 06, host read/write any time; bit 7 reserved.
// R11: cursor bit 6 enables the 64x64 sprite cursor; reset 0.
// R12: cursor bit 5 selects crosshair/cursor-area intersection format; reset 0.
// R13: cursor bit 4 selects sprite data format: 0 first, 1 windowing.
// R14: cursor bit 3 picks crosshair color: 0 color 0, 1 color 1.
// R15: cursor bit 2 shows the crosshair when set; reset 0.
// R16: cursor bits 1:0 give crosshair thickness 1, 3, 5 or 7 pixels.
// R17: crosshair segments are centered on the cursor position coordinate.
// R18: in legacy mode sync inputs pass through without polarity change.
// R19: any write to soft reset index ff restores both registers to defaults.
// R20: reserved cursor bit 7 ignores writes and reads back zero.
package pcr_pkg;
  // register indices on the host port
  localparam logic [7:0] IDX_CURSOR_CONTROL = 8'h06;
  localparam logic [7:0] IDX_GENERAL_CONTROL = 8'h1d;
  localparam logic [7:0] IDX_SOFT_RESET = 8'hff;
  // values after reset, and the cursor-control write mask
  localparam logic [7:0] GC_RESET = 8'h20;
  localparam logic [7:0] CC_RESET = 8'h00;
  localparam logic [7:0] CC_WRITE_MASK = 8'h7f;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // general-control field positions
  localparam int unsigned GC_OVS_SRC = 7;
  localparam int unsigned GC_OVS_EN = 6;
  localparam int unsigned GC_SOG = 5;
  localparam int unsigned GC_PEDESTAL = 4;
  localparam int unsigned GC_BYTE_ORDER = 3;
  localparam int unsigned GC_SPLIT = 2;
  localparam int unsigned GC_VS_POL = 1;
  localparam int unsigned GC_HS_POL = 0;
  // cursor-control field positions
  localparam int unsigned CC_RSVD = 7;
  localparam int unsigned CC_SPRITE_EN = 6;
  localparam int unsigned CC_ISECT = 5;
  localparam int unsigned CC_SPRITE_FMT = 4;
  localparam int unsigned CC_XH_COLOR = 3;
  localparam int unsigned CC_XH_EN = 2;
  localparam int unsigned CC_XH_THICK_LSB = 0;
  // timing of the split transfer shift pulse
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SPLIT_HIGH_MIN_NS = 15;
  localparam int unsigned SPLIT_HIGH_RAW =
    (SPLIT_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SPLIT_HIGH_CYCLES = (SPLIT_HIGH_RAW < 1) ? 1 : SPLIT_HIGH_RAW;
  localparam logic [3:0] SPLIT_CNT_LAST = 4'(SPLIT_HIGH_CYCLES - 1);
  // split transfer pulse sequencer
  typedef enum logic [1:0] {
    PCR_SPLIT_IDLE,
    PCR_SPLIT_PULSE,
    PCR_SPLIT_HOLD
  } pcr_split_state_t;
endpackage

//--- hw/pcr_sync_pol.sv
// pcr_sync_pol: one sync output with programmable polarity and legacy bypass.
// assumes the system sync input is an active-low pulse on clk_i.
`timescale 1ns/1ps
`default_nettype none
module pcr_sync_pol (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // controls
  input wire logic legacy_mode_i,
  input wire logic polarity_i,
  // sync sources
  input wire logic sys_sync_n_i,
  input wire logic legacy_sync_i,
  // registered output
  output logic sync_o
);
  logic next_sync;
  logic sync_q;

  // true/complement gate, bypassed in legacy mode
  always_comb begin
    if (legacy_mode_i) begin
      next_sync = legacy_sync_i; // R18
    end else begin
      next_sync = sys_sync_n_i ^ polarity_i; // R8 R9
    end
  end

  // output flop; idles high like an inactive low-true sync
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_q <= 1'b1;
    end else begin
      sync_q <= next_sync;
    end
  end

  assign sync_o = sync_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // polarity applies only outside legacy mode
  a_sync_polarity: assert property ( // R9
    !legacy_mode_i |=> sync_o == ($past(sys_sync_n_i) ^ $past(polarity_i)))
    else $error("sync polarity wrong");
  a_legacy_pass: assert property ( // R18
    legacy_mode_i |=> sync_o == $past(legacy_sync_i))
    else $error("legacy sync not passed through");
endmodule
`default_nettype wire

//--- hw/pcr_crosshair.sv
// pcr_crosshair: decides if the current pixel lies on the crosshair.
// assumes pixel and cursor coordinates are stable for one clk_i each.
`timescale 1ns/1ps
`default_nettype none
module pcr_crosshair #(
  parameter int unsigned COORD_W = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // controls
  input wire logic enable_i,
  input wire logic [1:0] thickness_i,
  // coordinates
  input wire logic [COORD_W-1:0] pixel_x_i,
  input wire logic [COORD_W-1:0] pixel_y_i,
  input wire logic [COORD_W-1:0] cursor_x_i,
  input wire logic [COORD_W-1:0] cursor_y_i,
  // registered hit
  output logic hit_o
);
  logic [COORD_W-1:0] dist_x;
  logic [COORD_W-1:0] dist_y;
  logic [COORD_W-1:0] half;
  logic next_hit;
  logic hit_q;

  // distance from the cursor on each axis
  function automatic logic [COORD_W-1:0] absdiff(input logic [COORD_W-1:0] a,
                                                 input logic [COORD_W-1:0] b);
    absdiff = (a >= b) ? a - b : b - a;
  endfunction

  // thickness 2n+1 pixels, centered on the cursor position
  always_comb begin
    dist_x = absdiff(pixel_x_i, cursor_x_i);
    dist_y = absdiff(pixel_y_i, cursor_y_i);
    half = COORD_W'(thickness_i); // R16
    next_hit = enable_i && ((dist_x <= half) || (dist_y <= half)); // R17 R15
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= next_hit;
    end
  end

  assign hit_o = hit_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_crosshair_center: assert property ( // R17
    enable_i && pixel_x_i == cursor_x_i |=> hit_o)
    else $error("cursor column not on crosshair");
  a_crosshair_hidden: assert property ( // R15
    !enable_i |=> !hit_o)
    else $error("crosshair shown while disabled");
endmodule
`default_nettype wire

//--- hw/pcr_palette_ctrl.sv
// pcr_palette_ctrl: general and cursor control registers on the indexed
// host port, plus the small datapath pieces those bits steer directly.
// assumes host strobes and all pins are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module pcr_palette_ctrl #(
  parameter int unsigned PIX_BYTES = 8,
  parameter int unsigned COORD_W = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // indexed host register port
  input wire logic [7:0] reg_index_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // general-control fields
  output logic overscan_source_select_o,
  output logic overscan_border_enable_o,
  output logic sync_on_green_enable_o,
  output logic pedestal_select_o,
  output logic pixel_byte_order_o,
  output logic split_transfer_enable_o,
  output logic vsync_out_polarity_o,
  output logic hsync_out_polarity_o,
  // cursor-control fields
  output logic sprite_cursor_enable_o,
  output logic intersection_format_o,
  output logic sprite_data_format_o,
  output logic crosshair_color_select_o,
  output logic crosshair_enable_o,
  output logic [1:0] crosshair_thickness_o,
  // overscan
  input wire logic overscan_input_pin_i,
  input wire logic overscan_internal_i,
  output logic overscan_o,
  // sync
  input wire logic legacy_mode_i,
  input wire logic sys_hsync_n_i,
  input wire logic sys_vsync_n_i,
  input wire logic legacy_hsync_i,
  input wire logic legacy_vsync_i,
  input wire logic composite_sync_i,
  output logic horizontal_sync_output_o,
  output logic vertical_sync_output_o,
  output logic green_current_output_sync_o,
  // pixel bus
  input wire logic [8*PIX_BYTES-1:0] pixel_in_i,
  output logic [8*PIX_BYTES-1:0] pixel_out_o,
  // split shift-register transfer
  input wire logic split_flag_i,
  output logic split_shift_pulse_o,
  // crosshair
  input wire logic [COORD_W-1:0] pixel_x_i,
  input wire logic [COORD_W-1:0] pixel_y_i,
  input wire logic [COORD_W-1:0] cursor_x_i,
  input wire logic [COORD_W-1:0] cursor_y_i,
  output logic crosshair_pixel_o
);
  // register state
  logic [7:0] general_control;
  logic [7:0] cursor_control;
  logic [7:0] next_general_control;
  logic [7:0] next_cursor_control;
  logic [7:0] next_rdata;
  logic [7:0] rdata;

  // index decode, shared by write and read paths
  function automatic logic hit_index(input logic [7:0] idx, input logic [7:0] want);
    hit_index = (idx == want);
  endfunction

  logic wr_gc;
  logic wr_cc;
  logic wr_soft_reset;

  assign wr_gc = reg_wr_i && hit_index(reg_index_i, pcr_pkg::IDX_GENERAL_CONTROL);
  assign wr_cc = reg_wr_i && hit_index(reg_index_i, pcr_pkg::IDX_CURSOR_CONTROL);
  assign wr_soft_reset = reg_wr_i && hit_index(reg_index_i, pcr_pkg::IDX_SOFT_RESET);

  // register writes; soft reset restores defaults whatever data is written
  always_comb begin
    next_general_control = general_control;
    next_cursor_control = cursor_control;
    if (wr_soft_reset) begin
      next_general_control = pcr_pkg::GC_RESET; // R19
      next_cursor_control = pcr_pkg::CC_RESET; // R19
    end else if (wr_gc) begin
      next_general_control = reg_wdata_i; // R1
    end else if (wr_cc) begin
      next_cursor_control = reg_wdata_i & pcr_pkg::CC_WRITE_MASK; // R10 R20
    end
  end

  // read data; unmapped indices read zero
  always_comb begin
    next_rdata = rdata;
    if (reg_rd_i) begin
      if (hit_index(reg_index_i, pcr_pkg::IDX_GENERAL_CONTROL)) begin
        next_rdata = general_control; // R1
      end else if (hit_index(reg_index_i, pcr_pkg::IDX_CURSOR_CONTROL)) begin
        next_rdata = cursor_control & pcr_pkg::CC_WRITE_MASK; // R10 R20
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // register flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      general_control <= pcr_pkg::GC_RESET;
      cursor_control <= pcr_pkg::CC_RESET;
      rdata <= pcr_pkg::RDATA_RESET;
    end else begin
      general_control <= next_general_control;
      cursor_control <= next_cursor_control;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // general-control fields out
  assign overscan_source_select_o = general_control[pcr_pkg::GC_OVS_SRC]; // R2
  assign overscan_border_enable_o = general_control[pcr_pkg::GC_OVS_EN]; // R3
  assign sync_on_green_enable_o = general_control[pcr_pkg::GC_SOG]; // R4
  assign pedestal_select_o = general_control[pcr_pkg::GC_PEDESTAL]; // R5
  assign pixel_byte_order_o = general_control[pcr_pkg::GC_BYTE_ORDER]; // R6
  assign split_transfer_enable_o = general_control[pcr_pkg::GC_SPLIT]; // R7
  assign vsync_out_polarity_o = general_control[pcr_pkg::GC_VS_POL]; // R8
  assign hsync_out_polarity_o = general_control[pcr_pkg::GC_HS_POL]; // R9

  // cursor-control fields out
  assign sprite_cursor_enable_o = cursor_control[pcr_pkg::CC_SPRITE_EN]; // R11
  assign intersection_format_o = cursor_control[pcr_pkg::CC_ISECT]; // R12
  assign sprite_data_format_o = cursor_control[pcr_pkg::CC_SPRITE_FMT]; // R13
  assign crosshair_color_select_o = cursor_control[pcr_pkg::CC_XH_COLOR]; // R14
  assign crosshair_enable_o = cursor_control[pcr_pkg::CC_XH_EN]; // R15
  assign crosshair_thickness_o = cursor_control[pcr_pkg::CC_XH_THICK_LSB +: 2]; // R16

  // overscan border and sync-on-green, registered
  logic overscan_q;
  logic next_overscan;
  logic green_sync_q;
  logic next_green_sync;

  always_comb begin
    next_overscan = 1'b0;
    if (overscan_border_enable_o) begin // R3
      next_overscan = overscan_source_select_o ? overscan_internal_i
                                               : overscan_input_pin_i; // R2
    end
    next_green_sync = sync_on_green_enable_o && composite_sync_i; // R4
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overscan_q <= 1'b0;
      green_sync_q <= 1'b0;
    end else begin
      overscan_q <= next_overscan;
      green_sync_q <= next_green_sync;
    end
  end

  assign overscan_o = overscan_q;
  assign green_current_output_sync_o = green_sync_q;

  // sync outputs with programmable polarity
  pcr_sync_pol u_hsync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .legacy_mode_i(legacy_mode_i),
    .polarity_i(hsync_out_polarity_o),
    .sys_sync_n_i(sys_hsync_n_i),
    .legacy_sync_i(legacy_hsync_i),
    .sync_o(horizontal_sync_output_o)
  );

  pcr_sync_pol u_vsync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .legacy_mode_i(legacy_mode_i),
    .polarity_i(vsync_out_polarity_o),
    .sys_sync_n_i(sys_vsync_n_i),
    .legacy_sync_i(legacy_vsync_i),
    .sync_o(vertical_sync_output_o)
  );

  // pixel bus byte order: big endian mirrors the byte lanes
  logic [8*PIX_BYTES-1:0] swapped;
  logic [8*PIX_BYTES-1:0] pixel_q;
  logic [8*PIX_BYTES-1:0] next_pixel;

  for (genvar b = 0; b < PIX_BYTES; b++) begin : g_swap
    assign swapped[8*b +: 8] = pixel_in_i[8*(PIX_BYTES-1-b) +: 8];
  end

  always_comb begin
    next_pixel = pixel_byte_order_o ? swapped : pixel_in_i; // R6
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pixel_q <= '0;
    end else begin
      pixel_q <= next_pixel;
    end
  end

  assign pixel_out_o = pixel_q;

  // split transfer: one extra shift pulse per rising flag edge
  pcr_pkg::pcr_split_state_t split_state;
  pcr_pkg::pcr_split_state_t next_split_state;
  logic [3:0] split_cnt;
  logic [3:0] next_split_cnt;
  logic flag_q;

  always_comb begin
    next_split_state = split_state;
    next_split_cnt = split_cnt;
    case (split_state)
      pcr_pkg::PCR_SPLIT_IDLE: begin
        next_split_cnt = 4'h0;
        if (split_transfer_enable_o && split_flag_i && !flag_q) begin // R7
          next_split_state = pcr_pkg::PCR_SPLIT_PULSE;
        end
      end
      pcr_pkg::PCR_SPLIT_PULSE: begin
        if (split_cnt == pcr_pkg::SPLIT_CNT_LAST) begin
          next_split_state = pcr_pkg::PCR_SPLIT_HOLD;
        end else begin
          next_split_cnt = split_cnt + 4'h1;
        end
      end
      pcr_pkg::PCR_SPLIT_HOLD: begin
        if (!split_flag_i) begin
          next_split_state = pcr_pkg::PCR_SPLIT_IDLE;
        end
      end
      default: begin
        next_split_state = pcr_pkg::PCR_SPLIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      split_state <= pcr_pkg::PCR_SPLIT_IDLE;
      split_cnt <= 4'h0;
      flag_q <= 1'b0;
    end else begin
      split_state <= next_split_state;
      split_cnt <= next_split_cnt;
      flag_q <= split_flag_i;
    end
  end

  assign split_shift_pulse_o = (split_state == pcr_pkg::PCR_SPLIT_PULSE);

  // crosshair hit test
  pcr_crosshair #(
    .COORD_W(COORD_W)
  ) u_crosshair (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .enable_i(crosshair_enable_o),
    .thickness_i(crosshair_thickness_o),
    .pixel_x_i(pixel_x_i),
    .pixel_y_i(pixel_y_i),
    .cursor_x_i(cursor_x_i),
    .cursor_y_i(cursor_y_i),
    .hit_o(crosshair_pixel_o)
  );

  // checks on register and datapath behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_gc_write: assert property ( // R1
    wr_gc |=> general_control == $past(reg_wdata_i))
    else $error("general-control write lost");
  a_cc_write: assert property ( // R10
    wr_cc |=> cursor_control == {1'b0, $past(reg_wdata_i[6:0])})
    else $error("cursor-control write lost");
  a_cc_reserved_zero: assert property ( // R20
    reg_rd_i && hit_index(reg_index_i, pcr_pkg::IDX_CURSOR_CONTROL) |=> !reg_rdata_o[7])
    else $error("reserved bit read nonzero");
  a_gc_readback: assert property ( // R1
    reg_rd_i && hit_index(reg_index_i, pcr_pkg::IDX_GENERAL_CONTROL)
      |=> reg_rdata_o == $past(general_control))
    else $error("general-control read wrong");
  a_soft_reset_both: assert property ( // R19
    wr_soft_reset |=> general_control == pcr_pkg::GC_RESET
                      && cursor_control == pcr_pkg::CC_RESET)
    else $error("soft reset left state");
  a_overscan_select: assert property ( // R2
    overscan_border_enable_o && !overscan_source_select_o && !wr_gc && !wr_soft_reset
      |=> overscan_o == $past(overscan_input_pin_i))
    else $error("overscan source wrong");
  a_overscan_off: assert property ( // R3
    !overscan_border_enable_o |=> !overscan_o)
    else $error("overscan while disabled");
  a_sog_gate: assert property ( // R4
    !sync_on_green_enable_o |=> !green_current_output_sync_o)
    else $error("sync on green while disabled");
  a_byte_order: assert property ( // R6
    pixel_byte_order_o |=> pixel_out_o[7:0] == $past(pixel_in_i[8*PIX_BYTES-1 -: 8]))
    else $error("byte order wrong");
  a_split_pulse: assert property ( // R7
    split_state == pcr_pkg::PCR_SPLIT_IDLE && split_transfer_enable_o
      && split_flag_i && !flag_q |=> split_shift_pulse_o ##1 !split_shift_pulse_o)
    else $error("split pulse missing");
  a_split_off: assert property ( // R7
    !split_transfer_enable_o && split_state == pcr_pkg::PCR_SPLIT_IDLE
      |=> !split_shift_pulse_o)
    else $error("split pulse while disabled");

  c_soft_reset: cover property (wr_soft_reset);
  c_split_pulse: cover property (split_shift_pulse_o);
  c_big_endian: cover property (pixel_byte_order_o && !legacy_mode_i);
  c_crosshair: cover property (crosshair_pixel_o && crosshair_thickness_o == 2'b11);
endmodule
`default_nettype wire

//--- test/tb_pcr_palette_ctrl.sv
// tb_pcr_palette_ctrl: self-checking bench for the palette control registers.
// assumes the indexed host port of pcr_palette_ctrl and a 20 MHz clk_i.
`timescale 1ns/1ps
`default_nettype none
module tb_pcr_palette_ctrl;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_index_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic os_src, os_en, sog, ped, bord, split_en, vs_pol, hs_pol;
  logic spr_en, isect, spr_fmt, xh_col, xh_en;
  logic [1:0] xh_thick;
  logic overscan_input_pin_i = 1'b0;
  logic overscan_internal_i = 1'b0;
  logic overscan_o;
  logic legacy_mode_i = 1'b0;
  logic sys_hsync_n_i = 1'b1;
  logic sys_vsync_n_i = 1'b1;
  logic legacy_hsync_i = 1'b0;
  logic legacy_vsync_i = 1'b0;
  logic composite_sync_i = 1'b0;
  logic hs_out, vs_out, green_sync;
  logic [63:0] pixel_in_i = 64'h0706050403020100;
  logic [63:0] pixel_out_o;
  logic split_flag_i = 1'b0;
  logic split_shift_pulse_o;
  logic [11:0] pixel_x_i = 12'h000;
  logic [11:0] pixel_y_i = 12'h000;
  logic [11:0] cursor_x_i = 12'd100;
  logic [11:0] cursor_y_i = 12'd200;
  logic crosshair_pixel_o;
  logic [7:0] gc_f;
  logic [7:0] cc_f;
  int err_total = 0;
  int checked = 0;
  int cnt;

  // field outputs gathered in register bit order
  assign gc_f = {os_src, os_en, sog, ped, bord, split_en, vs_pol, hs_pol};
  assign cc_f = {1'b0, spr_en, isect, spr_fmt, xh_col, xh_en, xh_thick};

  pcr_palette_ctrl u_pcr_palette_ctrl (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .reg_index_i(reg_index_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .overscan_source_select_o(os_src), .overscan_border_enable_o(os_en),
    .sync_on_green_enable_o(sog), .pedestal_select_o(ped),
    .pixel_byte_order_o(bord), .split_transfer_enable_o(split_en),
    .vsync_out_polarity_o(vs_pol), .hsync_out_polarity_o(hs_pol),
    .sprite_cursor_enable_o(spr_en), .intersection_format_o(isect),
    .sprite_data_format_o(spr_fmt), .crosshair_color_select_o(xh_col),
    .crosshair_enable_o(xh_en), .crosshair_thickness_o(xh_thick),
    .overscan_input_pin_i(overscan_input_pin_i), .overscan_internal_i(overscan_internal_i),
    .overscan_o(overscan_o), .legacy_mode_i(legacy_mode_i),
    .sys_hsync_n_i(sys_hsync_n_i), .sys_vsync_n_i(sys_vsync_n_i),
    .legacy_hsync_i(legacy_hsync_i), .legacy_vsync_i(legacy_vsync_i),
    .composite_sync_i(composite_sync_i), .horizontal_sync_output_o(hs_out),
    .vertical_sync_output_o(vs_out), .green_current_output_sync_o(green_sync),
    .pixel_in_i(pixel_in_i), .pixel_out_o(pixel_out_o),
    .split_flag_i(split_flag_i), .split_shift_pulse_o(split_shift_pulse_o),
    .pixel_x_i(pixel_x_i), .pixel_y_i(pixel_y_i),
    .cursor_x_i(cursor_x_i), .cursor_y_i(cursor_y_i),
    .crosshair_pixel_o(crosshair_pixel_o)
  );

  // 50 ns clock
  always #25 clk_i = ~clk_i;

  // compare and report
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one-cycle write strobe, launched at a falling edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clk_i);
    reg_index_i = idx;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  // one-cycle read strobe, data compared one cycle later
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    @(negedge clk_i);
    reg_index_i = idx;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk("reg_rdata_o", {56'h0, e}, {56'h0, reg_rdata_o});
  endtask

  // verdict and end of run
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #2000000;
    err_total++;
    $display("BAD run_time expected end seen timeout");
    wrap_up();
  end

  // main sequence
  initial begin
    cyc(5);
    resetn_i = 1'b1;
    chk("gc_fields", 8'h20, gc_f);
    chk("cc_fields", 8'h00, cc_f);
    rd_chk(8'h1d, 8'h20);
    rd_chk(8'h06, 8'h00);
    // walking one through every bit of both registers
    for (int i = 0; i < 8; i++) begin
      wr(8'h1d, 8'h01 << i);
      chk("gc_fields", 8'h01 << i, gc_f);
      rd_chk(8'h1d, 8'h01 << i);
      wr(8'h06, 8'h01 << i);
      chk("cc_fields", (8'h01 << i) & 8'h7f, cc_f);
      rd_chk(8'h06, (8'h01 << i) & 8'h7f);
    end
    wr(8'h06, 8'hff);
    rd_chk(8'h06, 8'h7f);
    rd_chk(8'h42, 8'h00);
    // soft reset, then a hardware reset in mid-run
    wr(8'h1d, 8'hdf);
    wr(8'hff, 8'h5a);
    chk("gc_fields", 8'h20, gc_f);
    chk("cc_fields", 8'h00, cc_f);
    rd_chk(8'h06, 8'h00);
    wr(8'h1d, 8'h00);
    wr(8'h06, 8'h7f);
    resetn_i = 1'b0;
    cyc(1);
    chk("gc_fields", 8'h20, gc_f);
    chk("cc_fields", 8'h00, cc_f);
    resetn_i = 1'b1;
    // overscan source and border enable
    for (int m = 0; m < 8; m++) begin
      wr(8'h1d, {m[1:0], 6'h00});
      overscan_input_pin_i = m[2];
      overscan_internal_i = ~m[2];
      cyc(1);
      chk("overscan_o", m[0] & (m[1] ? ~m[2] : m[2]), overscan_o);
    end
    // sync polarity, legacy bypass, sync on green
    for (int k = 0; k < 8; k++) begin
      wr(8'h1d, {2'b00, k[2], 3'b000, k[0], ~k[0]});
      sys_hsync_n_i = k[1];
      sys_vsync_n_i = k[1];
      legacy_hsync_i = ~k[1];
      legacy_vsync_i = k[1];
      legacy_mode_i = k[2];
      composite_sync_i = k[1];
      cyc(1);
      // one-bit cast keeps the inversions from widening to the 64-bit compare
      chk("hsync_out", 1'(k[2] ? ~k[1] : k[1] ^ ~k[0]), hs_out);
      chk("vsync_out", k[2] ? k[1] : k[1] ^ k[0], vs_out);
      chk("green_sync", k[2] & k[1], green_sync);
    end
    legacy_mode_i = 1'b0;
    // pixel byte order
    wr(8'h1d, 8'h08);
    cyc(1);
    chk("pixel_out_o", 64'h0001020304050607, pixel_out_o);
    wr(8'h1d, 8'h00);
    cyc(1);
    chk("pixel_out_o", 64'h0706050403020100, pixel_out_o);
    // split transfer pulse: none when disabled, exactly one when enabled
    for (int e = 0; e < 3; e++) begin
      wr(8'h1d, (e > 0) ? 8'h04 : 8'h00);
      split_flag_i = 1'b0;
      cyc(2);
      split_flag_i = 1'b1;
      cnt = 0;
      repeat (6) begin
        cyc(1);
        if (split_shift_pulse_o === 1'b1) cnt++;
      end
      split_flag_i = 1'b0;
      chk("split_pulses", (e > 0) ? 1 : 0, cnt);
    end
    // crosshair thickness centered on the cursor position
    for (int t = 0; t < 4; t++) begin
      wr(8'h06, 8'h04 | 8'(t));
      pixel_y_i = 12'd900;
      pixel_x_i = 12'(100 + t);
      cyc(1);
      chk("xh_hit", 1, crosshair_pixel_o);
      pixel_x_i = 12'(100 - t);
      cyc(1);
      chk("xh_hit", 1, crosshair_pixel_o);
      pixel_x_i = 12'(101 + t);
      cyc(1);
      chk("xh_hit", 0, crosshair_pixel_o);
      pixel_x_i = 12'd900;
      pixel_y_i = 12'(200 - t);
      cyc(1);
      chk("xh_hit", 1, crosshair_pixel_o);
      pixel_y_i = 12'(199 - t);
      cyc(1);
      chk("xh_hit", 0, crosshair_pixel_o);
    end
    wr(8'h06, 8'h03);
    pixel_x_i = 12'd100;
    cyc(1);
    chk("xh_hit", 0, crosshair_pixel_o);
    wrap_up();
  end
endmodule
`default_nettype wire
